// file: hdl/ref_status_pkg.sv
// Constants for the reference status and storage control register bank.
// Assumes byte-wide registers at 16-bit addresses on a plain strobe port.
//
// Overview of operation
// - Valid flag set only when reference unfaulted and timer expired.
// - Fault flag set whenever the reference is not valid for use.
// - Too-fast flag set when measured frequency is above the profile limit.
// - Too-slow flag set when measured frequency is below the profile limit.
// - Missing clock sets too-fast and too-slow flags together.
// - Reference status refreshes only when 0x01 is written to 0x0005.
// - 30-bit tuning word read as four bytes, low byte at 0x0D0D.
// - Phase lock level: bits 7:0 at 0x0D11, bits 11:8 low nibble next.
// - Frequency lock level: bits 7:0 at 0x0D13, bits 11:8 at 0x0D14.
// - Write-enable bit 0 of 0x0E00 acts at once; default protects storage.
// - Four-bit load condition at 0x0E01, default zero, acts at once.
// - Writing 1 to 0x0E02 bit 0 starts a save; bit clears itself.
// - Writing 1 to 0x0E03 bit 1 starts a load; bit clears itself.

package ref_status_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ***************************************************************
    // Register offsets
    // ***************************************************************
    localparam logic [15:0] ADDR_UPDATE      = 16'h0005;
    localparam logic [15:0] ADDR_RSVD_A      = 16'h0D0A;
    localparam logic [15:0] ADDR_REF_STATUS  = 16'h0D0B;
    localparam logic [15:0] ADDR_RSVD_B      = 16'h0D0C;
    localparam logic [15:0] ADDR_TW_BYTE0    = 16'h0D0D;
    localparam logic [15:0] ADDR_TW_BYTE1    = 16'h0D0E;
    localparam logic [15:0] ADDR_TW_BYTE2    = 16'h0D0F;
    localparam logic [15:0] ADDR_TW_BYTE3    = 16'h0D10;
    localparam logic [15:0] ADDR_PHASE_LO    = 16'h0D11;
    localparam logic [15:0] ADDR_PHASE_HI    = 16'h0D12;
    localparam logic [15:0] ADDR_FREQ_LO     = 16'h0D13;
    localparam logic [15:0] ADDR_FREQ_HI     = 16'h0D14;
    localparam logic [15:0] ADDR_NVM_WP      = 16'h0E00;
    localparam logic [15:0] ADDR_NVM_COND    = 16'h0E01;
    localparam logic [15:0] ADDR_NVM_SAVE    = 16'h0E02;
    localparam logic [15:0] ADDR_NVM_LOAD    = 16'h0E03;
    localparam logic [15:0] ADDR_IRQ_STATUS  = 16'h0E04;
    localparam logic [15:0] ADDR_IRQ_MASK    = 16'h0E05;

    // ***************************************************************
    // Field positions and codes
    // ***************************************************************
    localparam logic [7:0] UPDATE_CMD   = 8'h01;
    localparam int         REF_FIELD_W  = 4;
    localparam int         BIT_SLOW     = 0;
    localparam int         BIT_FAST     = 1;
    localparam int         BIT_FAULT    = 2;
    localparam int         BIT_VALID    = 3;
    localparam int         BIT_WP       = 0;
    localparam int         BIT_SAVE     = 0;
    localparam int         BIT_LOAD     = 1;
    localparam int         COND_W       = 4;
    localparam int         IRQ_W        = 5;
    localparam int         IRQ_FAULT0   = 0;
    localparam int         IRQ_FAULT1   = 1;
    localparam int         IRQ_VALID0   = 2;
    localparam int         IRQ_VALID1   = 3;
    localparam int         IRQ_NVM_DONE = 4;

    // ***************************************************************
    // Reset values
    // ***************************************************************
    localparam logic [7:0] RST_REF_STATUS = 8'h44;
    localparam logic       RST_WP         = 1'b0;
    localparam logic [3:0] RST_COND       = 4'h0;
    localparam logic [4:0] RST_IRQ        = 5'h00;

endpackage : ref_status_pkg

// file: hdl/ref_status_and_nvm_control.sv
// Reference status snapshot, lock readback and storage control registers.
// Assumes monitor, history and storage logic share mclk_i with this bank.

`timescale 1ns/1ps

module ref_status_and_nvm_control
    import ref_status_pkg::*;
#(
    parameter int TW_WIDTH  = 30,
    parameter int TUB_WIDTH = 12
) (
    input  wire logic                 mclk_i,
    input  wire logic                 srst_i,
    input  wire logic [ADDR_W-1:0]    addr_i,
    input  wire logic [DATA_W-1:0]    wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [DATA_W-1:0]    rdata_o,
    input  wire logic [1:0]           ref_unfaulted_i,
    input  wire logic [1:0]           ref_timer_done_i,
    input  wire logic [1:0]           ref_above_limit_i,
    input  wire logic [1:0]           ref_below_limit_i,
    input  wire logic [1:0]           ref_clock_missing_i,
    input  wire logic [TW_WIDTH-1:0]  tuning_word_i,
    input  wire logic [TUB_WIDTH-1:0] phase_lock_level_i,
    input  wire logic [TUB_WIDTH-1:0] freq_lock_level_i,
    input  wire logic                 nvm_busy_i,
    output logic                      update_strobe_o,
    output logic                      nvm_write_enable_o,
    output logic      [COND_W-1:0]    nvm_load_condition_o,
    output logic                      nvm_save_start_o,
    output logic                      nvm_load_start_o,
    output logic                      irq_o
);

    // ***************************************************************
    // Elaboration checks
    // ***************************************************************
    if (TW_WIDTH < 1 || TW_WIDTH > 32) begin : g_bad_tw
        $error("TW_WIDTH must lie between 1 and 32");
    end
    if (TUB_WIDTH < 1 || TUB_WIDTH > 12) begin : g_bad_tub
        $error("TUB_WIDTH must lie between 1 and 12");
    end

    // ***************************************************************
    // Decode
    // ***************************************************************
    logic        wr_update;
    logic        wr_wp;
    logic        wr_cond;
    logic        wr_save;
    logic        wr_load;
    logic        wr_mask;
    logic        rd_irq;
    logic [31:0] tw32;
    logic [15:0] phase16;
    logic [15:0] freq16;

    assign wr_update = wr_i && addr_i == ADDR_UPDATE
                       && wdata_i == UPDATE_CMD;
    assign wr_wp     = wr_i && addr_i == ADDR_NVM_WP;
    assign wr_cond   = wr_i && addr_i == ADDR_NVM_COND;
    assign wr_save   = wr_i && addr_i == ADDR_NVM_SAVE
                       && wdata_i[BIT_SAVE];
    assign wr_load   = wr_i && addr_i == ADDR_NVM_LOAD
                       && wdata_i[BIT_LOAD];
    assign wr_mask   = wr_i && addr_i == ADDR_IRQ_MASK;
    assign rd_irq    = rd_i && addr_i == ADDR_IRQ_STATUS;

    // Unused upper bits stay zero so reserved positions read zero
    assign tw32    = 32'(tuning_word_i);
    assign phase16 = 16'(phase_lock_level_i);
    assign freq16  = 16'(freq_lock_level_i);

    // ***************************************************************
    // Reference status snapshot
    // ***************************************************************
    logic [7:0] ref_status_reg;
    logic [7:0] ref_status_next;
    logic [7:0] ref_live;

    always_comb begin
        ref_live = 8'h00;
        for (int r = 0; r < 2; r++) begin
            ref_live[r*REF_FIELD_W + BIT_VALID] =
                ref_unfaulted_i[r] && ref_timer_done_i[r];
            ref_live[r*REF_FIELD_W + BIT_FAULT] =
                !(ref_unfaulted_i[r] && ref_timer_done_i[r]);
            ref_live[r*REF_FIELD_W + BIT_FAST] =
                ref_above_limit_i[r] || ref_clock_missing_i[r];
            ref_live[r*REF_FIELD_W + BIT_SLOW] =
                ref_below_limit_i[r] || ref_clock_missing_i[r];
        end
    end

    // Snapshot keeps the status byte stable between updates; tuning word and lock levels read live
    always_comb begin
        ref_status_next = ref_status_reg;
        if (wr_update) begin
            ref_status_next = ref_live;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ref_status_reg <= RST_REF_STATUS;
        end else begin
            ref_status_reg <= ref_status_next;
        end
    end

    a_valid_flag: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        wr_update |=> ref_status_reg[BIT_VALID] ==
            $past(ref_unfaulted_i[0] && ref_timer_done_i[0]))
        else $error("first reference valid flag wrong");

    a_fault_flag: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        ref_status_reg[BIT_FAULT] != ref_status_reg[BIT_VALID]
        && ref_status_reg[REF_FIELD_W + BIT_FAULT]
           != ref_status_reg[REF_FIELD_W + BIT_VALID])
        else $error("fault flag not inverse of valid");

    a_fast_flag: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        wr_update && ref_above_limit_i[1]
        |=> ref_status_reg[REF_FIELD_W + BIT_FAST])
        else $error("second reference fast flag missing");

    a_slow_flag: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        wr_update |=> ref_status_reg[BIT_SLOW] ==
            $past(ref_below_limit_i[0] || ref_clock_missing_i[0]))
        else $error("first reference slow flag wrong");

    a_missing_both: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        wr_update && ref_clock_missing_i[0]
        |=> ref_status_reg[BIT_FAST] && ref_status_reg[BIT_SLOW])
        else $error("missing clock not shown as fast and slow");

    a_status_hold: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        !wr_update |=> $stable(ref_status_reg))
        else $error("status changed without update strobe");

    // ***************************************************************
    // Storage control
    // ***************************************************************
    logic              wp_reg;
    logic              wp_next;
    logic [COND_W-1:0] cond_reg;
    logic [COND_W-1:0] cond_next;
    logic              save_reg;
    logic              save_next;
    logic              load_reg;
    logic              load_next;
    logic              update_reg;
    logic              update_next;

    always_comb begin
        wp_next     = wp_reg;
        cond_next   = cond_reg;
        update_next = wr_update;
        // Trigger bits live one cycle, then clear themselves
        save_next   = wr_save;
        load_next   = wr_load;
        if (wr_wp) begin
            wp_next = wdata_i[BIT_WP];
        end
        if (wr_cond) begin
            cond_next = wdata_i[COND_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wp_reg     <= RST_WP;
            cond_reg   <= RST_COND;
            save_reg   <= 1'b0;
            load_reg   <= 1'b0;
            update_reg <= 1'b0;
        end else begin
            wp_reg     <= wp_next;
            cond_reg   <= cond_next;
            save_reg   <= save_next;
            load_reg   <= load_next;
            update_reg <= update_next;
        end
    end

    assign nvm_write_enable_o   = wp_reg;
    assign nvm_load_condition_o = cond_reg;
    assign nvm_save_start_o     = save_reg;
    assign nvm_load_start_o     = load_reg;
    assign update_strobe_o      = update_reg;

    a_wp_live: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        wr_wp |=> nvm_write_enable_o == $past(wdata_i[BIT_WP]))
        else $error("write enable not applied at once");

    a_cond_live: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        wr_cond ##1 !wr_cond
        |=> nvm_load_condition_o == $past(wdata_i[3:0], 2))
        else $error("load condition not applied");

    a_save_pulse: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        wr_save && !$past(wr_save) ##1 !wr_save
        |-> nvm_save_start_o ##1 !nvm_save_start_o)
        else $error("save trigger not a single pulse");

    a_load_pulse: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        nvm_load_start_o |-> $past(wr_load))
        else $error("load trigger without write");

    a_load_bit: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        wr_i && addr_i == ADDR_NVM_LOAD && !wdata_i[BIT_LOAD]
        |=> !nvm_load_start_o)
        else $error("load started by wrong bit");

    // ***************************************************************
    // Interrupts
    // ***************************************************************
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_status_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_mask_next;
    logic [IRQ_W-1:0] irq_set;
    logic             busy_prev_reg;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_FAULT0] = wr_update && ref_live[BIT_FAULT]
                              && !ref_status_reg[BIT_FAULT];
        irq_set[IRQ_FAULT1] = wr_update
                              && ref_live[REF_FIELD_W + BIT_FAULT]
                              && !ref_status_reg[REF_FIELD_W + BIT_FAULT];
        irq_set[IRQ_VALID0] = wr_update && ref_live[BIT_VALID]
                              && !ref_status_reg[BIT_VALID];
        irq_set[IRQ_VALID1] = wr_update
                              && ref_live[REF_FIELD_W + BIT_VALID]
                              && !ref_status_reg[REF_FIELD_W + BIT_VALID];
        irq_set[IRQ_NVM_DONE] = busy_prev_reg && !nvm_busy_i;
        // An event in the clearing read cycle survives it
        irq_status_next = irq_status_reg;
        if (rd_irq) begin
            irq_status_next = '0;
        end
        irq_status_next = irq_status_next | irq_set;
        irq_mask_next   = irq_mask_reg;
        if (wr_mask) begin
            irq_mask_next = wdata_i[IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_status_reg <= RST_IRQ;
            irq_mask_reg   <= RST_IRQ;
            busy_prev_reg  <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_mask_reg   <= irq_mask_next;
            busy_prev_reg  <= nvm_busy_i;
        end
    end

    assign irq_o = |(irq_status_reg & irq_mask_reg);

    // ***************************************************************
    // Read path
    // ***************************************************************
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    always_comb begin
        rdata_next = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                ADDR_REF_STATUS: rdata_next = ref_status_reg;
                ADDR_TW_BYTE0:   rdata_next = tw32[7:0];
                ADDR_TW_BYTE1:   rdata_next = tw32[15:8];
                ADDR_TW_BYTE2:   rdata_next = tw32[23:16];
                ADDR_TW_BYTE3:   rdata_next = tw32[31:24];
                ADDR_PHASE_LO:   rdata_next = phase16[7:0];
                ADDR_PHASE_HI:   rdata_next = {4'h0, phase16[11:8]};
                ADDR_FREQ_LO:    rdata_next = freq16[7:0];
                ADDR_FREQ_HI:    rdata_next = {4'h0, freq16[11:8]};
                ADDR_NVM_WP:     rdata_next = {7'h00, wp_reg};
                ADDR_NVM_COND:   rdata_next = {4'h0, cond_reg};
                ADDR_NVM_SAVE:   rdata_next = {7'h00, save_reg};
                ADDR_NVM_LOAD:   rdata_next = {6'h00, load_reg, 1'b0};
                ADDR_IRQ_STATUS: rdata_next = {3'h0, irq_status_reg};
                ADDR_IRQ_MASK:   rdata_next = {3'h0, irq_mask_reg};
                // Reserved and unmapped addresses read zero
                default:         rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;

    a_tw_low: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        rd_i && addr_i == ADDR_TW_BYTE0 |=> rdata_o == $past(tw32[7:0]))
        else $error("tuning word low byte read wrong");

    a_tw_read: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        rd_i && addr_i == ADDR_TW_BYTE3 |=> rdata_o == $past(tw32[31:24]))
        else $error("tuning word top byte read wrong");

    a_phase_high: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        rd_i && addr_i == ADDR_PHASE_HI
        |=> rdata_o[7:4] == 4'h0 && rdata_o[3:0] == $past(phase16[11:8]))
        else $error("phase lock level high read wrong");

    a_freq_low: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        rd_i && addr_i == ADDR_FREQ_LO |=> rdata_o == $past(freq16[7:0]))
        else $error("frequency lock level low read wrong");

    a_freq_high: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        rd_i && addr_i == ADDR_FREQ_HI
        |=> rdata_o == {4'h0, $past(freq16[11:8])})
        else $error("frequency lock level high read wrong");

    a_rsvd_zero: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        rd_i && (addr_i == ADDR_RSVD_A || addr_i == ADDR_RSVD_B)
        |=> rdata_o == 8'h00)
        else $error("reserved register read not zero");

endmodule : ref_status_and_nvm_control

// file: verif/ref_status_and_nvm_control_tb.sv
// Self-checking bench for the reference status and storage control bank.
// Assumes the bench alone drives every port; read data is queue-checked.

`timescale 1ns/1ps

module ref_status_and_nvm_control_tb;
    import ref_status_pkg::*;

    // ***************************************************************
    // Stimulus and observation signals
    // ***************************************************************
    logic              mclk_i, srst_i, wr_i, rd_i, nvm_busy_i;
    logic [15:0]       addr_i;
    logic [7:0]        wdata_i, rdata_o, prev_snap, new_snap, irq_acc;
    logic [1:0]        unf_i, tmr_i, abv_i, blw_i, mis_i;
    logic [29:0]       tw_i;
    logic [11:0]       ph_i, fr_i;
    logic              upd_o, wen_o, save_o, load_o, irq_o, rd_seen;
    logic [3:0]        cond_o;
    logic [7:0]        exp_q[$];
    logic [15:0]       rsvd_addr[4] = '{16'h0D0A, 16'h0D0C,
                                        16'h1234, 16'h0E06};
    int                n_mismatch = 0;
    int                n_checks   = 0;

    ref_status_and_nvm_control dut_u (
        .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ref_unfaulted_i(unf_i), .ref_timer_done_i(tmr_i),
        .ref_above_limit_i(abv_i), .ref_below_limit_i(blw_i),
        .ref_clock_missing_i(mis_i), .tuning_word_i(tw_i),
        .phase_lock_level_i(ph_i), .freq_lock_level_i(fr_i),
        .nvm_busy_i(nvm_busy_i), .update_strobe_o(upd_o),
        .nvm_write_enable_o(wen_o), .nvm_load_condition_o(cond_o),
        .nvm_save_start_o(save_o), .nvm_load_start_o(load_o), .irq_o(irq_o)
    );

    // ***************************************************************
    // Clock, tasks and own model of the status byte
    // ***************************************************************
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // Returns just after the edge that takes the write
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        exp_q.push_back(e);
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
    endtask : rd_reg

    function automatic logic [7:0] exp_status();
        logic [7:0] s;
        for (int i = 0; i < 2; i++) begin
            s[4*i+3] = unf_i[i] & tmr_i[i];
            s[4*i+2] = ~(unf_i[i] & tmr_i[i]);
            s[4*i+1] = abv_i[i] | mis_i[i];
            s[4*i]   = blw_i[i] | mis_i[i];
        end
        return s;
    endfunction : exp_status

    task automatic busy_pulse();
        @(posedge mclk_i);
        nvm_busy_i <= 1'b1;
        @(posedge mclk_i);
        nvm_busy_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask : busy_pulse

    // ***************************************************************
    // Read-data monitor: data only in the cycle after a read strobe
    // ***************************************************************
    always @(posedge mclk_i) begin
        if (srst_i) begin
            rd_seen <= 1'b0;
        end else begin
            if (rd_seen) begin
                if (exp_q.size() == 0) begin
                    n_mismatch++;
                    $display("[ERR] t=%0t read data with no note", $time);
                end else begin
                    chk(rdata_o, exp_q.pop_front());
                end
            end else begin
                chk(rdata_o, 8'h00);
            end
            rd_seen <= rd_i;
        end
    end

    // Watchdog: a hang ends in the same report
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        tally_and_finish();
    end

    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        {srst_i, wr_i, rd_i, nvm_busy_i} = 4'b1000;
        addr_i = 16'h0000; wdata_i = 8'h00;
        {unf_i, tmr_i, abv_i, blw_i, mis_i} = 10'h000;
        tw_i = 30'h0; ph_i = 12'h0; fr_i = 12'h0;
        void'($urandom(89));
        repeat (16) @(posedge mclk_i);
        srst_i <= 1'b0;
        #1;
        chk({3'h0, wen_o, cond_o}, 8'h00);
        rd_reg(ADDR_REF_STATUS, RST_REF_STATUS);
        rd_reg(ADDR_NVM_WP, 8'h00);
        rd_reg(ADDR_NVM_COND, 8'h00);

        // Reference events through the snapshot, then storage-done events
        {unf_i, tmr_i} <= 4'hF;
        wr_reg(ADDR_IRQ_MASK, 8'hFF);
        rd_reg(ADDR_IRQ_MASK, 8'h1F);
        wr_reg(ADDR_UPDATE, UPDATE_CMD);
        chk({6'h0, upd_o, irq_o}, 8'h03);
        rd_reg(ADDR_IRQ_STATUS, 8'h0C);
        chk({7'h0, irq_o}, 8'h00);
        rd_reg(ADDR_REF_STATUS, 8'h88);
        unf_i <= 2'b00;
        wr_reg(ADDR_UPDATE, UPDATE_CMD);
        rd_reg(ADDR_IRQ_STATUS, 8'h03);
        rd_reg(ADDR_REF_STATUS, 8'h44);
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        busy_pulse();
        chk({7'h0, irq_o}, 8'h00);
        rd_reg(ADDR_IRQ_STATUS, 8'h10);
        wr_reg(ADDR_IRQ_MASK, 8'h10);
        busy_pulse();
        chk({7'h0, irq_o}, 8'h01);
        rd_reg(ADDR_IRQ_STATUS, 8'h10);
        chk({7'h0, irq_o}, 8'h00);
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        prev_snap = 8'h44;
        irq_acc   = 8'h00;

        // Random monitor states; snapshot only on the exact update code
        for (int i = 0; i < 12; i++) begin
            {unf_i, tmr_i, abv_i, blw_i} <= 8'($urandom());
            mis_i <= (i == 0) ? 2'b11 : 2'($urandom());
            tw_i <= 30'($urandom());
            ph_i <= 12'($urandom());
            fr_i <= 12'($urandom());
            wr_reg(ADDR_UPDATE, 8'h02);
            chk({7'h0, upd_o}, 8'h00);
            rd_reg(ADDR_REF_STATUS, prev_snap);
            new_snap = exp_status();
            // Rising valid and fault flags against the old snapshot
            irq_acc = irq_acc | {4'h0, new_snap[7] & ~prev_snap[7],
                                 new_snap[3] & ~prev_snap[3],
                                 new_snap[6] & ~prev_snap[6],
                                 new_snap[2] & ~prev_snap[2]};
            wr_reg(ADDR_UPDATE, UPDATE_CMD);
            chk({7'h0, upd_o}, 8'h01);
            {unf_i, tmr_i, abv_i, blw_i, mis_i} <= 10'($urandom());
            rd_reg(ADDR_REF_STATUS, new_snap);
            prev_snap = new_snap;
            wr_reg(ADDR_TW_BYTE0, 8'($urandom()));
            rd_reg(ADDR_TW_BYTE0, tw_i[7:0]);
            rd_reg(ADDR_TW_BYTE1, tw_i[15:8]);
            rd_reg(ADDR_TW_BYTE2, tw_i[23:16]);
            rd_reg(ADDR_TW_BYTE3, {2'h0, tw_i[29:24]});
            rd_reg(ADDR_PHASE_LO, ph_i[7:0]);
            rd_reg(ADDR_PHASE_HI, {4'h0, ph_i[11:8]});
            rd_reg(ADDR_FREQ_LO, fr_i[7:0]);
            rd_reg(ADDR_FREQ_HI, {4'h0, fr_i[11:8]});
        end
        rd_reg(ADDR_IRQ_STATUS, irq_acc);
        repeat (2) @(posedge mclk_i);

        // Live control fields; reserved bits stay zero
        wr_reg(ADDR_NVM_WP, 8'hFF);
        chk({7'h0, wen_o}, 8'h01);
        rd_reg(ADDR_NVM_WP, 8'h01);
        wr_reg(ADDR_NVM_WP, 8'hFE);
        chk({7'h0, wen_o}, 8'h00);
        wr_reg(ADDR_NVM_COND, 8'hA5);
        chk({4'h0, cond_o}, 8'h05);
        rd_reg(ADDR_NVM_COND, 8'h05);

        // Triggers: right bit only, one-cycle pulse, read back zero
        wr_reg(ADDR_NVM_SAVE, 8'h01);
        chk({6'h0, save_o, load_o}, 8'h02);
        @(posedge mclk_i);
        #1;
        chk({6'h0, save_o, load_o}, 8'h00);
        rd_reg(ADDR_NVM_SAVE, 8'h00);
        busy_pulse();
        wr_reg(ADDR_NVM_SAVE, 8'hFE);
        chk({7'h0, save_o}, 8'h00);
        wr_reg(ADDR_NVM_LOAD, 8'h01);
        chk({7'h0, load_o}, 8'h00);
        wr_reg(ADDR_NVM_LOAD, 8'h02);
        chk({6'h0, save_o, load_o}, 8'h01);
        @(posedge mclk_i);
        #1;
        chk({7'h0, load_o}, 8'h00);
        rd_reg(ADDR_NVM_LOAD, 8'h00);
        busy_pulse();

        // Interrupted load: the bench resets the bank before going on
        wr_reg(ADDR_NVM_COND, 8'h03);
        wr_reg(ADDR_NVM_WP, 8'h01);
        wr_reg(ADDR_NVM_LOAD, 8'h02);
        nvm_busy_i <= 1'b1;
        srst_i     <= 1'b1;
        repeat (2) @(posedge mclk_i);
        nvm_busy_i <= 1'b0;
        srst_i     <= 1'b0;
        #1;
        chk({3'h0, upd_o, save_o, load_o, irq_o, wen_o}, 8'h00);
        chk({4'h0, cond_o}, 8'h00);
        rd_reg(ADDR_REF_STATUS, RST_REF_STATUS);
        rd_reg(ADDR_IRQ_STATUS, 8'h00);

        // Reserved and unmapped places ignore writes and read zero
        foreach (rsvd_addr[k]) begin
            wr_reg(rsvd_addr[k], 8'hFF);
            rd_reg(rsvd_addr[k], 8'h00);
        end
        repeat (3) @(posedge mclk_i);
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("[ERR] t=%0t reads left unanswered", $time);
        end
        tally_and_finish();
    end

endmodule : ref_status_and_nvm_control_tb
